// >>> src/serial_audio_pkg.sv
// Constants and carrier types for the serial audio port pin function block
package serial_audio_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 12;
  localparam int NUM_TX = 6;
  localparam int NUM_RX = 4;
  localparam int NUM_PORTS = 2;

  // ----------------------------------------------------------------
  // Pin positions within one port
  // ----------------------------------------------------------------
  localparam int PIN_RX_BCLK = 0;
  localparam int PIN_RX_FS = 1;
  localparam int PIN_RX_HF = 2;
  localparam int PIN_TX_BCLK = 3;
  localparam int PIN_TX_FS = 4;
  localparam int PIN_TX_HF = 5;
  localparam int PIN_DATA0 = 6;

  // ----------------------------------------------------------------
  // Register map (byte offsets inside one port window)
  // ----------------------------------------------------------------
  localparam int PORT_SEL_BIT = 6;
  localparam logic [4:0] OFS_COMMON_CTRL = 5'h00;
  localparam logic [4:0] OFS_RX_CLOCK_CTRL = 5'h04;
  localparam logic [4:0] OFS_TX_CLOCK_CTRL = 5'h08;
  localparam logic [4:0] OFS_CHANNEL_EN = 5'h0C;
  localparam logic [4:0] OFS_COMMON_STATUS = 5'h10;
  localparam logic [4:0] OFS_PORT_CTRL = 5'h14;
  localparam logic [4:0] OFS_PORT_DIR = 5'h18;
  localparam logic [4:0] OFS_PORT_DATA = 5'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CC_SYNC = 0;
  localparam int CC_OF0 = 1;
  localparam int CC_OF1 = 2;
  localparam int CC_TX_EXT_BUFFER_ENABLE_BIT = 3;
  localparam int CC_NET = 4;
  localparam int CK_BCLK_DIR = 0;
  localparam int CK_FS_DIR = 1;
  localparam int CK_HF_DIR = 2;
  localparam int CK_HF_SRC = 3;
  localparam int CE_RX_LSB = 8;
  localparam int ST_IF0 = 0;
  localparam int ST_IF1 = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] COMMON_CTRL_RESET = 5'h00;
  localparam logic [3:0] CLOCK_CTRL_RESET = 4'h0;
  localparam logic [11:0] PORT_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] out;
    logic [11:0] oe;
  } pin_drive_t;

  typedef struct packed {
    logic rx_bit_clock;
    logic rx_frame_sync;
    logic rx_hf_clock;
    logic tx_bit_clock;
    logic tx_frame_sync;
    logic tx_hf_clock;
    logic tx_buffer_enable;
    logic frame_strobe;
    logic slot_strobe;
    logic [5:0] tx_bits;
  } engine_out_t;

  typedef struct packed {
    logic rx_bit_clock;
    logic rx_frame_sync;
    logic rx_hf_clock;
    logic tx_bit_clock;
    logic tx_frame_sync;
    logic tx_hf_clock;
    logic rx_clock_from_hf;
    logic tx_clock_from_hf;
    logic [3:0] rx_bits;
    logic [5:0] tx_active;
    logic [3:0] rx_active;
  } engine_in_t;

endpackage

// >>> src/serial_audio_pins.sv
// Pin function control for two serial audio ports behind one APB slave
// Operation
// RULE1: Async mode: rx clock pin is receiver bit clock; sync mode: flag 0.
// RULE2: Flag 0 direction follows the receiver clock direction bit.
// RULE3: Output flag 0 drives its control bit, updated on frame or slot.
// RULE4: Input flag 0 captured into status on frame or slot strobe.
// RULE5: Tx clock pin clocks transmitters, plus receivers in sync mode.
// RULE6: Serial outputs 0..5 carry transmit shift registers 0..5 when enabled.
// RULE7: Serial inputs 0..3 feed receivers, sharing pins with outputs 5..2.
// RULE8: In port mode each pin is input, output or disconnected.
// RULE9: After reset every pin is a disconnected port pin.
// RULE10: Rx high-frequency input selectable as receiver clock; else output.
// RULE11: Tx high-frequency input selectable as transmitter clock; else output.
// RULE12: Async mode: rx frame sync pin is the receivers' frame sync.
// RULE13: Sync mode: rx frame sync pin is flag 1, or buffer enable.
// RULE14: Flag 1 direction follows the receiver frame sync direction bit.
// RULE15: Flag 1 output drives control bit; input captured on frame or slot.
// RULE16: Tx frame sync serves both sides in sync, transmitters in async.
// RULE17: Tx frame sync direction follows its direction bit.
// RULE18: Two identical port instances, each with own registers and pins.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps

module port_pin_function (
  // Core clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link clock of this port
  input wire logic link_clk,
  // Register access
  input wire logic wr_en,
  input wire logic [4:0] offset,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data,
  output logic rd_hit,
  // Pins
  input wire logic [11:0] pin_in,
  output serial_audio_pkg::pin_drive_t pins,
  // Audio engine
  input wire serial_audio_pkg::engine_out_t engine_out,
  output serial_audio_pkg::engine_in_t engine_in
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [4:0] common_ctrl;
  logic [3:0] rx_ctrl;
  logic [3:0] tx_ctrl;
  logic [5:0] tx_en;
  logic [3:0] rx_en;
  logic [11:0] port_ctrl;
  logic [11:0] port_dir;
  logic [11:0] port_data;

  function automatic logic [5:0] reverse6(input logic [5:0] v);
    reverse6 = {v[0], v[1], v[2], v[3], v[4], v[5]};
  endfunction

  wire sel_cc = offset == serial_audio_pkg::OFS_COMMON_CTRL;
  wire sel_rc = offset == serial_audio_pkg::OFS_RX_CLOCK_CTRL;
  wire sel_tc = offset == serial_audio_pkg::OFS_TX_CLOCK_CTRL;
  wire sel_ce = offset == serial_audio_pkg::OFS_CHANNEL_EN;
  wire sel_st = offset == serial_audio_pkg::OFS_COMMON_STATUS;
  wire sel_pc = offset == serial_audio_pkg::OFS_PORT_CTRL;
  wire sel_pd = offset == serial_audio_pkg::OFS_PORT_DIR;
  wire sel_pv = offset == serial_audio_pkg::OFS_PORT_DATA;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      common_ctrl <= serial_audio_pkg::COMMON_CTRL_RESET;
      rx_ctrl <= serial_audio_pkg::CLOCK_CTRL_RESET;
      tx_ctrl <= serial_audio_pkg::CLOCK_CTRL_RESET;
      tx_en <= 6'h00;
      rx_en <= 4'h0;
      port_ctrl <= serial_audio_pkg::PORT_RESET; // RULE9
      port_dir <= serial_audio_pkg::PORT_RESET; // RULE9
      port_data <= serial_audio_pkg::PORT_RESET;
    end else if (wr_en) begin
      if (sel_cc) common_ctrl <= wr_data[4:0];
      if (sel_rc) rx_ctrl <= wr_data[3:0];
      if (sel_tc) tx_ctrl <= wr_data[3:0];
      if (sel_ce) tx_en <= wr_data[5:0];
      if (sel_ce) rx_en <= wr_data[11:8];
      if (sel_pc) port_ctrl <= wr_data[11:0];
      if (sel_pd) port_dir <= wr_data[11:0];
      if (sel_pv) port_data <= wr_data[11:0];
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  wire sync_mode_bit = common_ctrl[serial_audio_pkg::CC_SYNC];
  wire tx_ext_buffer_enable_bit = common_ctrl[serial_audio_pkg::CC_TX_EXT_BUFFER_ENABLE_BIT];
  wire rx_clock_direction_bit = rx_ctrl[serial_audio_pkg::CK_BCLK_DIR];
  wire rx_frame_sync_direction_bit = rx_ctrl[serial_audio_pkg::CK_FS_DIR];
  wire rx_hf_dir = rx_ctrl[serial_audio_pkg::CK_HF_DIR];
  wire rx_hf_src = rx_ctrl[serial_audio_pkg::CK_HF_SRC];
  wire tx_clock_dir = tx_ctrl[serial_audio_pkg::CK_BCLK_DIR];
  wire tx_frame_sync_direction_bit = tx_ctrl[serial_audio_pkg::CK_FS_DIR];
  wire tx_hf_dir = tx_ctrl[serial_audio_pkg::CK_HF_DIR];
  wire tx_hf_src = tx_ctrl[serial_audio_pkg::CK_HF_SRC];

  // Pin mode: ctrl/dir 00 off, 01 port out, 10 port in, 11 function
  wire [11:0] func_sel = port_ctrl & port_dir;
  wire [11:0] gpio_out = ~port_ctrl & port_dir; // RULE8
  wire [11:0] gpio_in = port_ctrl & ~port_dir; // RULE8

  // ----------------------------------------------------------------
  // Pin inputs into the core domain
  // ----------------------------------------------------------------
  logic [11:0] pin_meta;
  logic [11:0] pin_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 12'h000;
      pin_sync <= 12'h000;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // Core to link crossing of the flag controls (slow levels)
  // ----------------------------------------------------------------
  wire [2:0] cfg_src = {common_ctrl[serial_audio_pkg::CC_NET],
                        common_ctrl[serial_audio_pkg::CC_OF1],
                        common_ctrl[serial_audio_pkg::CC_OF0]};
  logic [2:0] cfg_meta;
  logic [2:0] cfg_sync;
  logic [5:0] link_meta;
  logic [5:0] link_sync;
  logic [1:0] out_flag;
  logic [1:0] in_flag_link;
  logic [5:0] tx_bits_q;

  // Network mode moves the flag update from frame to slot boundary
  wire flag_strobe = cfg_sync[2] ? engine_out.slot_strobe
                                 : engine_out.frame_strobe;

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      cfg_meta <= 3'h0;
      cfg_sync <= 3'h0;
      link_meta <= 6'h00;
      link_sync <= 6'h00;
      out_flag <= 2'h0;
      in_flag_link <= 2'h0;
      tx_bits_q <= 6'h00;
    end else begin
      cfg_meta <= cfg_src;
      cfg_sync <= cfg_meta;
      link_meta <= {pin_in[9:6], pin_in[1:0]};
      link_sync <= link_meta;
      tx_bits_q <= engine_out.tx_bits; // RULE6
      if (flag_strobe) begin
        out_flag <= cfg_sync[1:0]; // RULE3 RULE15
        in_flag_link <= link_sync[1:0]; // RULE4 RULE15
      end
    end
  end

  // ----------------------------------------------------------------
  // Link to core crossing of the captured input flags
  // ----------------------------------------------------------------
  logic [1:0] iflag_meta;
  logic [1:0] iflag_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iflag_meta <= 2'h0;
      iflag_sync <= 2'h0;
    end else begin
      iflag_meta <= in_flag_link;
      iflag_sync <= iflag_meta;
    end
  end

  wire flag0_in = func_sel[serial_audio_pkg::PIN_RX_BCLK] & sync_mode_bit &
                  ~rx_clock_direction_bit;
  wire flag1_in = func_sel[serial_audio_pkg::PIN_RX_FS] & sync_mode_bit &
                  ~tx_ext_buffer_enable_bit & ~rx_frame_sync_direction_bit;
  wire in_flag_0 = flag0_in & iflag_sync[0]; // RULE4
  wire in_flag_1 = flag1_in & iflag_sync[1]; // RULE15

  // ----------------------------------------------------------------
  // Function drive per pin
  // ----------------------------------------------------------------
  wire rx_bclk_out = sync_mode_bit ? out_flag[0] // RULE1 RULE3
                                   : engine_out.rx_bit_clock;
  wire rx_fs_out = !sync_mode_bit ? engine_out.rx_frame_sync // RULE12
                 : tx_ext_buffer_enable_bit ? engine_out.tx_buffer_enable
                 : out_flag[1]; // RULE13 RULE15
  wire [5:0] data_oe = reverse6(tx_en); // RULE6
  wire [5:0] data_out = reverse6(tx_bits_q); // RULE6

  // Direction follows the same bit in clock and flag roles
  wire [11:0] fn_oe = {data_oe,
                       tx_hf_dir, // RULE11
                       tx_frame_sync_direction_bit, // RULE17
                       tx_clock_dir, // RULE5
                       rx_hf_dir, // RULE10
                       rx_frame_sync_direction_bit, // RULE14
                       rx_clock_direction_bit}; // RULE2
  wire [11:0] fn_out = {data_out,
                        engine_out.tx_hf_clock,
                        engine_out.tx_frame_sync, // RULE16
                        engine_out.tx_bit_clock, // RULE5
                        engine_out.rx_hf_clock,
                        rx_fs_out,
                        rx_bclk_out};

  // Disconnected pins neither drive nor pass their level inward
  assign pins.oe = (func_sel & fn_oe) | gpio_out; // RULE8 RULE9
  assign pins.out = (func_sel & fn_oe & fn_out) | (gpio_out & port_data);

  // ----------------------------------------------------------------
  // Inputs handed to the audio engine
  // ----------------------------------------------------------------
  wire [11:0] fn_in = func_sel & ~fn_oe & pin_sync;
  wire rx_pin_clk = ~sync_mode_bit & fn_in[serial_audio_pkg::PIN_RX_BCLK];
  wire rx_pin_fs = ~sync_mode_bit & fn_in[serial_audio_pkg::PIN_RX_FS];
  wire tx_pin_clk = fn_in[serial_audio_pkg::PIN_TX_BCLK];
  wire tx_pin_fs = fn_in[serial_audio_pkg::PIN_TX_FS];
  wire [3:0] tx_on_shared = {tx_en[2], tx_en[3], tx_en[4], tx_en[5]};
  // Transmit wins on a shared pin, so both never fight over it
  wire [3:0] rx_active = rx_en & ~tx_on_shared & func_sel[9:6]; // RULE7

  // Clock pins reach the engine as sampled levels, not as clocks
  assign engine_in.rx_bit_clock = sync_mode_bit ? tx_pin_clk // RULE5
                                                : rx_pin_clk; // RULE1
  assign engine_in.rx_frame_sync = sync_mode_bit ? tx_pin_fs // RULE16
                                                 : rx_pin_fs; // RULE12
  assign engine_in.tx_bit_clock = tx_pin_clk; // RULE5
  assign engine_in.tx_frame_sync = tx_pin_fs; // RULE16
  assign engine_in.rx_hf_clock = fn_in[serial_audio_pkg::PIN_RX_HF];
  assign engine_in.tx_hf_clock = fn_in[serial_audio_pkg::PIN_TX_HF];
  assign engine_in.rx_clock_from_hf = rx_hf_src & // RULE10
    func_sel[serial_audio_pkg::PIN_RX_HF] & ~rx_hf_dir;
  assign engine_in.tx_clock_from_hf = tx_hf_src & // RULE11
    func_sel[serial_audio_pkg::PIN_TX_HF] & ~tx_hf_dir;
  assign engine_in.rx_bits = rx_active & link_sync[5:2]; // RULE7
  assign engine_in.tx_active = tx_en & reverse6(func_sel[11:6]); // RULE6
  assign engine_in.rx_active = rx_active;

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  wire [11:0] port_read = (gpio_in & pin_sync) | (~gpio_in & port_data);
  wire [31:0] status = {30'h0, in_flag_1, in_flag_0};

  assign rd_hit = sel_cc | sel_rc | sel_tc | sel_ce | sel_st | sel_pc |
                  sel_pd | sel_pv;
  assign rd_data = ({32{sel_cc}} & {27'h0, common_ctrl}) |
                   ({32{sel_rc}} & {28'h0, rx_ctrl}) |
                   ({32{sel_tc}} & {28'h0, tx_ctrl}) |
                   ({32{sel_ce}} & {20'h0, rx_en, 2'h0, tx_en}) |
                   ({32{sel_st}} & status) |
                   ({32{sel_pc}} & {20'h0, port_ctrl}) |
                   ({32{sel_pd}} & {20'h0, port_dir}) |
                   ({32{sel_pv}} & {20'h0, port_read});

endmodule // port_pin_function

module serial_audio_pins (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Link clocks, one per port
  input wire logic [1:0] link_clk,
  // Pins, one group per port
  input wire logic [1:0][11:0] pin_in,
  output serial_audio_pkg::pin_drive_t [1:0] pins,
  // Audio engines, one per port
  input wire serial_audio_pkg::engine_out_t [1:0] engine_out,
  output serial_audio_pkg::engine_in_t [1:0] engine_in
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [1:0][31:0] port_rd_data;
  logic [1:0] port_hit;

  wire access = psel & penable;
  wire port_sel = paddr[serial_audio_pkg::PORT_SEL_BIT];
  wire upper_zero = (paddr[11:7] == 5'h00) & ~paddr[5];
  wire mapped = upper_zero & port_hit[port_sel];

  // Zero wait state: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = (access & mapped & ~pwrite) ? port_rd_data[port_sel]
                                              : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Two identical ports
  // ----------------------------------------------------------------
  for (genvar p = 0; p < serial_audio_pkg::NUM_PORTS; p++) begin : g_port
    wire port_wr = access & pwrite & mapped & (port_sel == 1'(p));

    port_pin_function u_port ( // RULE18
      .pclk(pclk),
      .presetn(presetn),
      .link_clk(link_clk[p]),
      .wr_en(port_wr),
      .offset(paddr[4:0]),
      .wr_data(pwdata),
      .rd_data(port_rd_data[p]),
      .rd_hit(port_hit[p]),
      .pin_in(pin_in[p]),
      .pins(pins[p]),
      .engine_out(engine_out[p]),
      .engine_in(engine_in[p])
    );
  end

endmodule // serial_audio_pins

// >>> verification/serial_audio_pins_props.sv
// Assertion checker for the serial audio pin function block
`timescale 1ns/1ps
module serial_audio_pins_props (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Pins and engines
  input wire serial_audio_pkg::pin_drive_t [1:0] pins,
  input wire serial_audio_pkg::engine_out_t [1:0] engine_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr_hit;
  logic [11:0] mctl, mdir, mdat;
  assign acc = psel && penable;
  assign wr_hit = acc && pwrite;
  // Shadow of port 0 pin modes, so port pins can be told from function pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mctl <= 12'h000;
      mdir <= 12'h000;
      mdat <= 12'h000;
    end else begin
      if (wr_hit && paddr == 12'h014) mctl <= pwdata[11:0];
      if (wr_hit && paddr == 12'h018) mdir <= pwdata[11:0];
      if (wr_hit && paddr == 12'h01C) mdat <= pwdata[11:0];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_ready; acc |-> pready; endproperty
  property p_idle; !acc |-> prdata == 32'h0; endproperty
  property p_err;
    acc && (paddr[5] || paddr[11:7] != 5'h00) |-> pslverr && prdata == 32'h0;
  endproperty
  property p_ok;
    acc && paddr[11:7] == 5'h00 && !paddr[5] && paddr[1:0] == 2'h0
      |-> !pslverr;
  endproperty
  property p_rst; $rose(presetn) |-> (pins == 48'h0) [*2]; endproperty
  property p_gpio_oe;
    (pins[0].oe & ~(mctl & mdir)) == (~mctl & mdir);
  endproperty
  property p_gpio_out;
    (pins[0].out & ~mctl & mdir) == (mdat & ~mctl & mdir);
  endproperty
  property p_tx_clk;
    mctl[3] && mdir[3] && pins[0].oe[3]
      |-> pins[0].out[3] == engine_out[0].tx_bit_clock;
  endproperty
  property p_tx_fs;
    mctl[4] && mdir[4] && pins[0].oe[4]
      |-> pins[0].out[4] == engine_out[0].tx_frame_sync;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_idle: assert property (p_idle) else $error("prdata not zero when idle");
  a_err: assert property (p_err) else $error("unmapped access not refused");
  a_ok: assert property (p_ok) else $error("mapped access refused");
  a_rst: assert property (p_rst)
    else $error("pins driven after reset");
  a_gpio_oe: assert property (p_gpio_oe)
    else $error("port pin enable wrong");
  a_gpio_out: assert property (p_gpio_out)
    else $error("port pin value wrong");
  a_tx_clk: assert property (p_tx_clk)
    else $error("tx bit clock pin wrong");
  a_tx_fs: assert property (p_tx_fs)
    else $error("tx frame sync pin wrong");
  c_write: cover property (wr_hit && paddr == 12'h014);
  c_err: cover property (acc && pslverr);
  c_tx_clk: cover property (mctl[3] && pins[0].oe[3]);
endmodule // serial_audio_pins_props

bind serial_audio_pins serial_audio_pins_props serial_audio_pins_props_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .pins(pins), .engine_out(engine_out)
);

// >>> verification/codec_model.sv
// Far-side codec model that resolves each pin from both drivers
`timescale 1ns/1ps
module codec_model (
  // Device side of the pins
  input wire serial_audio_pkg::pin_drive_t pins,
  // Level the codec drives where the device does not
  input wire logic [11:0] ext_level,
  // Resolved wire level
  output logic [11:0] pin_level
);
  // A zero offer stands for the pull-down holding a released pin
  assign pin_level = (pins.oe & pins.out) | (~pins.oe & ext_level);
endmodule // codec_model

// >>> verification/tb_serial_audio_pins.sv
// Testbench for the serial audio pin function block
`timescale 1ns/1ps
module tb_serial_audio_pins;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, re;
  logic [1:0] link_clk = 2'b00;
  wire [1:0][11:0] pin_in;
  logic [1:0][11:0] ext = '0;
  serial_audio_pkg::pin_drive_t [1:0] pins;
  serial_audio_pkg::engine_out_t [1:0] eng = '0;
  serial_audio_pkg::engine_in_t [1:0] engine_in;
  int failures = 0;
  int tests_run = 0;

  always #5 pclk = ~pclk;
  initial begin
    #3;
    forever #40 link_clk = ~link_clk;
  end

  serial_audio_pins serial_audio_pins_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .link_clk(link_clk),
    .pin_in(pin_in), .pins(pins), .engine_out(eng), .engine_in(engine_in)
  );
  for (genvar g = 0; g < 2; g++) begin : g_codec
    codec_model codec_model_inst (
      .pins(pins[g]), .ext_level(ext[g]), .pin_level(pin_in[g])
    );
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int p, input logic [4:0] o, input logic [31:0] d);
    xfer((12'(p) << 6) | 12'(o), 1'b1, d);
  endtask

  task automatic rd(input int p, input logic [4:0] o, input logic [31:0] e);
    xfer((12'(p) << 6) | 12'(o), 1'b0, 32'h0);
    chk(e, rv);
  endtask

  task automatic lk(input int n);
    repeat (n) @(posedge link_clk[0]);
  endtask

  // One-link-cycle strobe on port 0, slot when s is set
  task automatic strobe(input logic s);
    @(posedge link_clk[0]);
    eng[0].slot_strobe <= s;
    eng[0].frame_strobe <= !s;
    @(posedge link_clk[0]);
    eng[0].slot_strobe <= 1'b0;
    eng[0].frame_strobe <= 1'b0;
    lk(3);
    @(posedge pclk);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    lk(2);
    for (int p = 0; p < 2; p++) begin
      chk(32'h0, 32'(pins[p].oe));
      for (int o = 0; o < 32; o += 4) rd(p, 5'(o), 32'h0);
    end
    xfer(12'h020, 1'b1, 32'hFFF);
    chk(32'h1, {31'h0, re});
    xfer(12'h060, 1'b0, 32'h0);
    chk(32'h1, {31'h0, re});
    wr(0, serial_audio_pkg::OFS_COMMON_STATUS, 32'h3);
    rd(0, serial_audio_pkg::OFS_COMMON_STATUS, 32'h0);
    // Port pins: 3:0 input, 7:4 output, 11:8 disconnected
    for (int p = 0; p < 2; p++) begin
      ext[p] <= 12'h005;
      wr(p, serial_audio_pkg::OFS_PORT_CTRL, 32'h00F);
      wr(p, serial_audio_pkg::OFS_PORT_DIR, 32'h0F0);
      wr(p, serial_audio_pkg::OFS_PORT_DATA, 32'hA5A);
      repeat (3) @(posedge pclk);
      chk(32'h0F0, 32'(pins[p].oe));
      chk(32'h050, 32'(pins[p].out & pins[p].oe));
      rd(p, serial_audio_pkg::OFS_PORT_DATA, 32'hA55);
      if (p == 0) chk(32'h0, 32'(pins[1].oe));
    end
    // Second reset in mid-run
    presetn <= 1'b0;
    lk(2);
    @(posedge pclk);
    presetn <= 1'b1;
    ext[0] <= 12'h000;
    lk(2);
    chk(32'h0, 32'(pins[0].oe | pins[1].oe));
    // Flag 0 as output, then as input
    wr(0, serial_audio_pkg::OFS_PORT_CTRL, 32'hFFF);
    wr(0, serial_audio_pkg::OFS_PORT_DIR, 32'hFFF);
    wr(0, serial_audio_pkg::OFS_COMMON_CTRL, 32'h03);
    wr(0, serial_audio_pkg::OFS_RX_CLOCK_CTRL, 32'h1);
    lk(4);
    chk(32'h1, 32'(pins[0].oe[0]));
    chk(32'h0, 32'(pins[0].out[0]));
    strobe(1'b0);
    chk(32'h1, 32'(pins[0].out[0]));
    wr(0, serial_audio_pkg::OFS_COMMON_CTRL, 32'h11);
    lk(4);
    strobe(1'b0);
    chk(32'h1, 32'(pins[0].out[0]));
    strobe(1'b1);
    chk(32'h0, 32'(pins[0].out[0]));
    wr(0, serial_audio_pkg::OFS_RX_CLOCK_CTRL, 32'h0);
    ext[0] <= 12'h001;
    lk(4);
    chk(32'h0, 32'(pins[0].oe[1:0]));
    strobe(1'b1);
    rd(0, serial_audio_pkg::OFS_COMMON_STATUS, 32'h1);
    ext[0] <= 12'h002;
    lk(4);
    strobe(1'b1);
    rd(0, serial_audio_pkg::OFS_COMMON_STATUS, 32'h2);
    // Flag 1 as output, then as buffer enable
    wr(0, serial_audio_pkg::OFS_RX_CLOCK_CTRL, 32'h2);
    wr(0, serial_audio_pkg::OFS_COMMON_CTRL, 32'h15);
    lk(4);
    strobe(1'b1);
    chk(32'h1, 32'(pins[0].out[1] & pins[0].oe[1]));
    wr(0, serial_audio_pkg::OFS_COMMON_CTRL, 32'h09);
    for (int v = 1; v >= 0; v--) begin
      @(posedge link_clk[0]);
      eng[0].tx_buffer_enable <= v[0];
      lk(3);
      chk(32'(v), 32'(pins[0].out[1] & pins[0].oe[1]));
    end
    // Async mode, then transmitter pins driven and sampled
    wr(0, serial_audio_pkg::OFS_COMMON_CTRL, 32'h00);
    wr(0, serial_audio_pkg::OFS_RX_CLOCK_CTRL, 32'h3);
    wr(0, serial_audio_pkg::OFS_TX_CLOCK_CTRL, 32'h3);
    for (int v = 1; v >= 0; v--) begin
      @(posedge link_clk[0]);
      eng[0].rx_bit_clock <= v[0];
      eng[0].rx_frame_sync <= v[0];
      eng[0].tx_bit_clock <= v[0];
      eng[0].tx_frame_sync <= v[0];
      lk(2);
      chk(v ? 32'h1B : 32'h0, 32'(pins[0].out[4:0]));
      chk(32'h1B, 32'(pins[0].oe[4:0]));
    end
    wr(0, serial_audio_pkg::OFS_TX_CLOCK_CTRL, 32'h0);
    ext[0] <= 12'h018;
    repeat (4) @(posedge pclk);
    chk(32'h3, {30'h0, engine_in[0].tx_bit_clock,
                engine_in[0].tx_frame_sync});
    // Sync mode: receivers take clock and frame sync from the tx pins
    wr(0, serial_audio_pkg::OFS_COMMON_CTRL, 32'h01);
    repeat (2) @(posedge pclk);
    chk(32'h3, {30'h0, engine_in[0].rx_bit_clock,
                engine_in[0].rx_frame_sync});
    // High-frequency pins as outputs, then as clock sources
    eng[0].rx_hf_clock <= 1'b1;
    eng[0].tx_hf_clock <= 1'b1;
    wr(0, serial_audio_pkg::OFS_RX_CLOCK_CTRL, 32'h4);
    wr(0, serial_audio_pkg::OFS_TX_CLOCK_CTRL, 32'h4);
    lk(2);
    chk(32'h9, 32'(pins[0].out[5:2] & pins[0].oe[5:2]));
    wr(0, serial_audio_pkg::OFS_RX_CLOCK_CTRL, 32'h8);
    wr(0, serial_audio_pkg::OFS_TX_CLOCK_CTRL, 32'h8);
    lk(2);
    chk(32'h3, {30'h0, engine_in[0].rx_clock_from_hf,
                engine_in[0].tx_clock_from_hf});
    // Data pins: transmit, then receive
    wr(0, serial_audio_pkg::OFS_CHANNEL_EN, 32'h03F);
    @(posedge link_clk[0]);
    eng[0].tx_bits <= 6'b100101;
    lk(3);
    chk(32'hFC0, 32'(pins[0].oe & 12'hFC0));
    chk(32'h29, 32'(pins[0].out[11:6]));
    wr(0, serial_audio_pkg::OFS_CHANNEL_EN, 32'hF00);
    ext[0] <= 12'h0C0;
    lk(4);
    chk(32'h0, 32'(pins[0].oe[9:6]));
    chk(32'h3, 32'(engine_in[0].rx_bits));
    chk(32'hF, 32'(engine_in[0].rx_active));
    wrap_up();
  end
endmodule // tb_serial_audio_pins
